// ### frm_top.sv
// frm_top: 2048x36 fifo with almost-full flag, replay and two mailboxes
// assumes both ports and all pins are driven relative to I_CLK
`timescale 1ns/1ps
module frm_top (
    input  wire logic                        I_CLK,
    input  wire logic                        I_SYS_RST,
    input  wire logic                        I_A_SELECT_N,
    input  wire logic                        I_A_DIRECTION,
    input  wire logic                        I_A_ENABLE,
    input  wire logic                        I_A_MAIL_SELECT,
    input  wire logic [frm_pkg::DATA_W-1:0]  I_A_BUS,
    output logic      [frm_pkg::DATA_W-1:0]  O_A_BUS,
    output logic                             O_A_BUS_OE,
    input  wire logic                        I_B_SELECT_N,
    input  wire logic                        I_B_DIRECTION,
    input  wire logic                        I_B_ENABLE,
    input  wire logic                        I_B_MAIL_SELECT,
    input  wire logic [frm_pkg::DATA_W-1:0]  I_B_BUS,
    output logic      [frm_pkg::DATA_W-1:0]  O_B_BUS,
    output logic                             O_B_BUS_OE,
    input  wire logic                        I_REPLAY_MODE,
    input  wire logic                        I_REPLAY_RESTART,
    input  wire logic                        I_SERIAL_ENABLE,
    input  wire logic                        I_SERIAL_SHIFT,
    input  wire logic                        I_SERIAL_DATA,
    output logic                             O_WRITE_SPACE_FLAG,
    output logic                             O_FILL_HIGH_WARNING_N,
    output logic                             O_OUTPUT_READY,
    output logic                             O_FILL_LOW_WARNING_N,
    output logic                             O_A_TO_B_MAIL_FULL_N,
    output logic                             O_B_TO_A_MAIL_FULL_N,
    input  wire logic [frm_pkg::REG_AW-1:0]  I_REG_ADDR,
    input  wire logic [frm_pkg::REG_DW-1:0]  I_REG_WDATA,
    input  wire logic                        I_REG_WR,
    input  wire logic                        I_REG_RD,
    output logic      [frm_pkg::REG_DW-1:0]  O_REG_RDATA
);
    import frm_pkg::*;

    localparam int PIN_W = 2 * DATA_W + 13;

    // pin resynchronisation, two stages
    wire  [PIN_W-1:0] pin_raw = {I_A_SELECT_N, I_A_DIRECTION, I_A_ENABLE, I_A_MAIL_SELECT,
                                 I_A_BUS, I_B_SELECT_N, I_B_DIRECTION, I_B_ENABLE,
                                 I_B_MAIL_SELECT, I_B_BUS, I_REPLAY_MODE, I_REPLAY_RESTART,
                                 I_SERIAL_ENABLE, I_SERIAL_SHIFT, I_SERIAL_DATA};
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s;

    // no reset here: the offset-load strap must be seen at the first edge after reset
    always_ff @(posedge I_CLK) begin
        pin_s1 <= pin_raw;
        pin_s  <= pin_s1;
    end

    logic              a_sel_n;
    logic              a_dir;
    logic              a_en;
    logic              a_mail;
    logic [DATA_W-1:0] a_bus;
    logic              b_sel_n;
    logic              b_dir;
    logic              b_en;
    logic              b_mail;
    logic [DATA_W-1:0] b_bus;
    logic              rpl_in;
    logic              rst_in;
    logic              ser_en;
    logic              ser_shift;
    logic              ser_data;

    assign {a_sel_n, a_dir, a_en, a_mail, a_bus, b_sel_n, b_dir, b_en, b_mail, b_bus,
            rpl_in, rst_in, ser_en, ser_shift, ser_data} = pin_s;

    // state
    logic [PTR_W-1:0]  wr_ptr;
    logic [PTR_W-1:0]  rd_ptr;
    logic [PTR_W-1:0]  shadow;
    logic [PTR_W-1:0]  wr_b;
    logic [PTR_W-1:0]  rd_a;
    logic [DATA_W-1:0] out_reg;
    logic              or_flag;
    logic              ae_n;
    logic              af_n;
    logic              wsf;
    logic              rpl_on;
    logic [1:0]        rpl_cnt;
    logic [OFS_W-1:0]  x_ofs;
    logic [OFS_W-1:0]  y_ofs;
    logic [SER_BITS-1:0] ser_sr;
    logic [4:0]        ser_cnt;
    frm_prg_e          prg_st;
    logic [REG_DW-1:0] reg_rdata;
    logic [DATA_W-1:0] mb_ab_data;
    logic [DATA_W-1:0] mb_ba_data;
    logic              mb_ab_full_n;
    logic              mb_ba_full_n;
    logic [DATA_W-1:0] mem_rdata;

    // port decodes
    wire a_act   = !a_sel_n && a_en;
    wire fifo_wr = a_act && a_dir && !a_mail && wsf;
    wire a_mb_wr = a_act && a_dir && a_mail;
    wire a_mb_rd = a_act && !a_dir && a_mail;
    wire b_act   = !b_sel_n && b_en;
    wire fifo_rd = b_act && b_dir && !b_mail && or_flag;
    wire b_mb_wr = b_act && !b_dir && b_mail;
    wire b_mb_rd = b_act && b_dir && b_mail;

    // read side: memory count excludes the output register word
    wire [PTR_W-1:0] fill_b    = wr_b - rd_ptr;
    wire             mem_avail = fill_b != '0;
    wire             rpl_enter = !rpl_on && rpl_in && or_flag;
    wire             rpl_exit  = rpl_on && !rpl_in;
    wire             restart   = rpl_on && rpl_in && rst_in
                                 && rpl_cnt == RPL_MIN_READS;
    wire             load      = restart || (mem_avail && (!or_flag || fifo_rd));
    wire [ADDR_W-1:0] mem_raddr = restart ? shadow[ADDR_W-1:0] : rd_ptr[ADDR_W-1:0];
    wire [PTR_W-1:0] next_rd   = restart ? shadow + PTR_W'(1)
                                         : rd_ptr + PTR_W'(load);

    // write side: shadow guards replay data while replay is on
    wire [PTR_W-1:0] rd_a_src    = rpl_on ? shadow : rd_ptr;
    wire [PTR_W-1:0] next_wr     = wr_ptr + PTR_W'(fifo_wr);
    wire [PTR_W-1:0] next_fill_a = next_wr - rd_a;
    wire [PTR_W-1:0] af_level    = FIFO_DEPTH - PTR_W'(y_ofs);
    wire [PTR_W-1:0] fill_a      = wr_ptr - rd_a;

    frm_mem u_mem (
        .i_clk   (I_CLK),
        .i_we    (fifo_wr),
        .i_waddr (wr_ptr[ADDR_W-1:0]),
        .i_wdata (a_bus),
        .i_raddr (mem_raddr),
        .o_rdata (mem_rdata)
    );

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            wr_ptr <= '0;
            wr_b   <= '0;
        end else begin
            wr_ptr <= next_wr;
            wr_b   <= wr_ptr;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rd_ptr  <= '0;
            or_flag <= 1'b0;
            out_reg <= '0;
            ae_n    <= 1'b0;
        end else begin
            rd_ptr  <= next_rd;
            or_flag <= load || (or_flag && !fifo_rd);
            if (load) begin
                out_reg <= mem_rdata;
            end
            ae_n    <= fill_b > PTR_W'(x_ofs);
        end
    end

    // replay mode and reads counted past the first replay word
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rpl_on  <= 1'b0;
            rpl_cnt <= '0;
            shadow  <= '0;
        end else begin
            if (rpl_enter) begin
                rpl_on <= 1'b1;
                shadow <= rd_ptr - PTR_W'(1);
            end else if (rpl_exit) begin
                rpl_on <= 1'b0;
            end
            if (rpl_enter || restart) begin
                rpl_cnt <= '0;
            end else if (fifo_rd && rpl_cnt != RPL_MIN_READS) begin
                rpl_cnt <= rpl_cnt + 2'h1;
            end
        end
    end

    // write-side flags: a read shows after two edges, a write at once
    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            rd_a <= '0;
            af_n <= 1'b1;
            wsf  <= 1'b0;
        end else begin
            rd_a <= rd_a_src;
            af_n <= next_fill_a < af_level;
            wsf  <= next_fill_a != FIFO_DEPTH && prg_st == PRG_DONE;
        end
    end

    // offsets: preset at reset, serial strap load, then register writes
    wire ofs_wr = I_REG_WR && I_REG_ADDR == REG_OFFSETS && prg_st == PRG_DONE;

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            prg_st  <= PRG_ARM;
            x_ofs   <= OFS_PRESET;
            y_ofs   <= OFS_PRESET;
            ser_sr  <= '0;
            ser_cnt <= '0;
        end else begin
            unique case (prg_st)
                PRG_ARM: begin
                    prg_st <= ser_en ? PRG_SHIFT : PRG_DONE;
                end
                PRG_SHIFT: begin
                    if (ser_shift) begin
                        ser_sr  <= {ser_sr[SER_BITS-2:0], ser_data};
                        ser_cnt <= ser_cnt + 5'h1;
                    end
                    if (ser_shift && ser_cnt == SER_LAST) begin
                        x_ofs  <= ser_sr[SER_BITS-2 -: OFS_W];
                        y_ofs  <= {ser_sr[OFS_W-2:0], ser_data};
                        prg_st <= PRG_DONE;
                    end
                end
                PRG_DONE: begin
                    if (ofs_wr) begin
                        x_ofs <= I_REG_WDATA[OFS_X_LSB +: OFS_W];
                        y_ofs <= I_REG_WDATA[OFS_Y_LSB +: OFS_W];
                    end
                end
                default: begin
                    prg_st <= PRG_DONE;
                end
            endcase
        end
    end

    frm_mailbox u_mb_ab (
        .i_clk    (I_CLK),
        .i_rst    (I_SYS_RST),
        .i_wr     (a_mb_wr),
        .i_rd     (b_mb_rd),
        .i_wdata  (a_bus),
        .o_data   (mb_ab_data),
        .o_full_n (mb_ab_full_n)
    );

    frm_mailbox u_mb_ba (
        .i_clk    (I_CLK),
        .i_rst    (I_SYS_RST),
        .i_wr     (b_mb_wr),
        .i_rd     (a_mb_rd),
        .i_wdata  (b_bus),
        .o_data   (mb_ba_data),
        .o_full_n (mb_ba_full_n)
    );

    // register read port
    logic [REG_DW-1:0] ofs_word;

    always_comb begin
        ofs_word = '0;
        ofs_word[OFS_X_LSB +: OFS_W] = x_ofs;
        ofs_word[OFS_Y_LSB +: OFS_W] = y_ofs;
    end

    wire [REG_DW-1:0] status_word = {24'h0, prg_st != PRG_DONE, rpl_on, mb_ba_full_n,
                                     mb_ab_full_n, ae_n, or_flag, af_n, wsf};
    wire [REG_DW-1:0] rd_sel = (I_REG_ADDR == REG_OFFSETS) ? ofs_word
                             : (I_REG_ADDR == REG_STATUS)  ? status_word
                             : (I_REG_ADDR == REG_FILL)    ? REG_DW'(fill_a)
                             : '0;

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= I_REG_RD ? rd_sel : '0;
        end
    end

    assign O_REG_RDATA           = reg_rdata;
    assign O_A_BUS               = mb_ba_data;
    assign O_A_BUS_OE            = !a_sel_n && !a_dir;
    assign O_B_BUS               = b_mail ? mb_ab_data : out_reg;
    assign O_B_BUS_OE            = !b_sel_n && b_dir;
    assign O_WRITE_SPACE_FLAG    = wsf;
    assign O_FILL_HIGH_WARNING_N = af_n;
    assign O_OUTPUT_READY        = or_flag;
    assign O_FILL_LOW_WARNING_N  = ae_n;
    assign O_A_TO_B_MAIL_FULL_N  = mb_ab_full_n;
    assign O_B_TO_A_MAIL_FULL_N  = mb_ba_full_n;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    a_af_goes_low: assert property (
        fifo_wr && next_fill_a >= af_level |=> !af_n)
        else $error("almost-full not low at threshold");
    a_af_high_fill: assert property (
        af_n && $stable(y_ofs) |-> fill_a < af_level || $past(rd_a) != rd_a)
        else $error("almost-full high above threshold");
    a_space_full: assert property (
        fifo_wr && next_fill_a == FIFO_DEPTH && rd_a_src == rd_a |=> !wsf [*2])
        else $error("write space flag not low when full");
    a_prog_blocks: assert property (
        prg_st != PRG_DONE |-> !fifo_wr ##1 !wsf)
        else $error("fifo write during offset loading");
    a_rpl_enter: assert property (
        rpl_enter |=> rpl_on && shadow == $past(rd_ptr) - PTR_W'(1))
        else $error("replay entry wrong");
    a_rpl_leave: assert property (
        rpl_on && !rpl_in |=> !rpl_on)
        else $error("replay not left");
    a_restart_load: assert property (
        restart |=> or_flag && rd_ptr == shadow + PTR_W'(1) && rpl_cnt == 2'h0)
        else $error("restart did not reload first word");
    a_noready_hold: assert property (
        !or_flag && !mem_avail && !restart |=> $stable(out_reg) && !or_flag)
        else $error("output word changed without ready");
    a_mail_block: assert property (
        !mb_ab_full_n && !b_mb_rd |=> !mb_ab_full_n && $stable(mb_ab_data))
        else $error("full mailbox changed");
    a_mail_free: assert property (
        b_mb_rd && !a_mb_wr |=> mb_ab_full_n)
        else $error("mailbox read did not free flag");
    a_mail_keep: assert property (
        !a_mb_wr |=> $stable(mb_ab_data))
        else $error("mailbox altered without write");
    a_ae_level: assert property (
        ##1 ae_n |-> $past(fill_b) > PTR_W'($past(x_ofs)))
        else $error("low warning high at low fill");

    c_restart:  cover property (restart ##[1:8] restart);
    c_rpl_full: cover property (rpl_on && !wsf);
    c_af_cycle: cover property (!af_n ##[1:20] af_n);
    c_mail:     cover property (a_mb_wr ##[1:10] b_mb_rd);
endmodule

// ### frm_pkg.sv
// frm_pkg: widths, presets, register map and state codes of the fifo block
// assumes one clock; every file of the block imports it
package frm_pkg;
    localparam int                DATA_W        = 36;
    localparam int                ADDR_W        = 11;
    localparam int                PTR_W         = 12;
    localparam int                MEM_WORDS     = 1 << ADDR_W;
    localparam logic [PTR_W-1:0]  FIFO_DEPTH    = PTR_W'(MEM_WORDS);
    localparam int                OFS_W         = 11;
    localparam logic [OFS_W-1:0]  OFS_PRESET    = 11'h008;
    localparam int                SER_BITS      = 2 * OFS_W;
    localparam logic [4:0]        SER_LAST      = 5'(SER_BITS - 1);
    localparam logic [1:0]        RPL_MIN_READS = 2'h2;
    localparam int                REG_AW        = 4;
    localparam int                REG_DW        = 32;
    localparam logic [REG_AW-1:0] REG_OFFSETS   = 4'h0;
    localparam logic [REG_AW-1:0] REG_STATUS    = 4'h4;
    localparam logic [REG_AW-1:0] REG_FILL      = 4'h8;
    localparam int                OFS_X_LSB     = 0;
    localparam int                OFS_Y_LSB     = 16;

    typedef enum logic [2:0] {
        PRG_ARM   = 3'h1,
        PRG_SHIFT = 3'h2,
        PRG_DONE  = 3'h4
    } frm_prg_e;
endpackage

// ### frm_mem.sv
// frm_mem: fifo word storage, one write port and one unregistered read port
// assumes the caller registers the read word
`timescale 1ns/1ps
module frm_mem (
    input  wire logic                        i_clk,
    input  wire logic                        i_we,
    input  wire logic [frm_pkg::ADDR_W-1:0]  i_waddr,
    input  wire logic [frm_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic [frm_pkg::ADDR_W-1:0]  i_raddr,
    output logic      [frm_pkg::DATA_W-1:0]  o_rdata
);
    import frm_pkg::*;

    logic [DATA_W-1:0] mem [MEM_WORDS];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = mem[i_raddr];
endmodule

// ### frm_mailbox.sv
// frm_mailbox: one mail word with its active-low full flag
// assumes write and read strobes are single-cycle decodes of the ports
`timescale 1ns/1ps
module frm_mailbox (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    input  wire logic [frm_pkg::DATA_W-1:0]  i_wdata,
    output logic      [frm_pkg::DATA_W-1:0]  o_data,
    output logic                             o_full_n
);
    import frm_pkg::*;

    wire take = i_wr && o_full_n;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_data   <= '0;
            o_full_n <= 1'b1;
        end else begin
            if (take) begin
                o_data <= i_wdata;
            end
            // a new write wins over a read of the other port
            if (take) begin
                o_full_n <= 1'b0;
            end else if (i_rd) begin
                o_full_n <= 1'b1;
            end
        end
    end
endmodule

// ### frm_port_b_model.sv
// frm_port_b_model: port b bus master, one fifo or mail operation per command
// assumes commands arrive by non-blocking assignment after a rising edge
`timescale 1ns/1ps
module frm_port_b_model (
    input  wire logic                        i_clk,
    input  wire logic [1:0]                  i_op,
    input  wire logic                        i_mail_view,
    input  wire logic [frm_pkg::DATA_W-1:0]  i_data,
    output logic                             o_select_n,
    output logic                             o_direction,
    output logic                             o_enable,
    output logic                             o_mail_select,
    output logic      [frm_pkg::DATA_W-1:0]  o_bus
);
    import frm_pkg::*;
    // op codes: 0 idle, 1 fifo read, 2 mail read, 3 mail write
    initial begin
        o_select_n    = 1'b1;
        o_direction   = 1'b1;
        o_enable      = 1'b0;
        o_mail_select = 1'b0;
        o_bus         = '0;
    end
    always @(posedge i_clk) begin
        o_select_n    <= 1'b0;
        o_enable      <= (i_op != 2'h0);
        o_direction   <= (i_op != 2'h3);
        o_mail_select <= i_op[1] | i_mail_view;
        // released data lines toggle so a stale word never looks valid
        o_bus         <= (i_op == 2'h3) ? i_data : ~o_bus;
    end
endmodule

// ### frm_top_test.sv
// frm_top_test: self-checking bench for mailboxes, replay and almost-full
// assumes the port b partner model; port a and registers are driven here
`timescale 1ns/1ps
module frm_top_test;
    import frm_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              a_sel_n = 1'b1, a_dir = 1'b0, a_en = 1'b0, a_mail = 1'b0;
    logic [DATA_W-1:0] a_bus = '0, o_a_bus, o_b_bus, b_bus, b_data = '0, last = '0;
    logic              b_sel_n, b_dir, b_en, b_mail, a_oe, b_oe, view = 1'b0;
    logic [1:0]        b_cmd = 2'h0;
    logic              mode = 1'b0, restart = 1'b0;
    logic              ser_en = 1'b0, ser_sh = 1'b0, ser_d = 1'b0;
    logic [SER_BITS-1:0] ser_word = {11'h005, 11'h009};
    logic              space, high_n, ready, low_n, ab_n, ba_n;
    logic [REG_AW-1:0] addr = '0;
    logic [REG_DW-1:0] wdata = '0, rdata;
    logic              wr = 1'b0, rd = 1'b0;
    logic [DATA_W-1:0] words[$], expq[$];
    int                errors = 0, samples_checked = 0, seed = 32'h019818F5;
    int                ridx = 0;
    initial begin
        forever #20 clk = ~clk;
    end
    frm_top u_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_A_SELECT_N(a_sel_n),
        .I_A_DIRECTION(a_dir), .I_A_ENABLE(a_en), .I_A_MAIL_SELECT(a_mail),
        .I_A_BUS(a_bus), .O_A_BUS(o_a_bus), .O_A_BUS_OE(a_oe), .I_B_SELECT_N(b_sel_n),
        .I_B_DIRECTION(b_dir), .I_B_ENABLE(b_en), .I_B_MAIL_SELECT(b_mail),
        .I_B_BUS(b_bus), .O_B_BUS(o_b_bus), .O_B_BUS_OE(b_oe), .I_REPLAY_MODE(mode),
        .I_REPLAY_RESTART(restart), .I_SERIAL_ENABLE(ser_en), .I_SERIAL_SHIFT(ser_sh),
        .I_SERIAL_DATA(ser_d), .O_WRITE_SPACE_FLAG(space), .O_FILL_HIGH_WARNING_N(high_n),
        .O_OUTPUT_READY(ready), .O_FILL_LOW_WARNING_N(low_n),
        .O_A_TO_B_MAIL_FULL_N(ab_n), .O_B_TO_A_MAIL_FULL_N(ba_n), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata));
    frm_port_b_model u_port_b (.i_clk(clk), .i_op(b_cmd), .i_mail_view(view),
        .i_data(b_data), .o_select_n(b_sel_n), .o_direction(b_dir), .o_enable(b_en),
        .o_mail_select(b_mail), .o_bus(b_bus));
    task automatic chk_flag(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic chk_word(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_reg(input string n, input logic [REG_DW-1:0] e, input logic [REG_DW-1:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic reg_op(input logic w, input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(posedge clk);
        wr <= w;
        rd <= ~w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w) chk_reg("register read", d, rdata);
    endtask
    task automatic a_op(input logic dir, input logic mail, input logic [DATA_W-1:0] d);
        @(posedge clk);
        a_sel_n <= 1'b0;
        a_dir <= dir;
        a_en <= 1'b1;
        a_mail <= mail;
        a_bus <= d;
        @(posedge clk);
        a_sel_n <= 1'b1;
        a_en <= 1'b0;
        a_bus <= ~d;
    endtask
    task automatic b_op(input logic [1:0] op);
        @(posedge clk);
        b_cmd <= op;
        @(posedge clk);
        b_cmd <= 2'h0;
    endtask
    task automatic fifo_write(input int n);
        logic [DATA_W-1:0] d;
        repeat (n) begin
            d = DATA_W'({$random(seed), $random(seed)});
            if (words.size() == ridx) expq.push_back(d);
            words.push_back(d);
            a_op(1'b1, 1'b0, d);
        end
    endtask
    task automatic fifo_read();
        ridx++;
        expq.push_back(words[ridx]);
        b_op(2'h1);
    endtask
    // each new word on port b while ready is compared with the oldest note
    always @(posedge clk) begin
        last <= o_b_bus;
        if (!rst && !view && ready === 1'b1 && o_b_bus !== last) begin
            if (expq.size() == 0) chk_word("unexpected word", last, o_b_bus);
            else chk_word("fifo word", expq.pop_front(), o_b_bus);
        end
    end
    initial begin
        cyc(2);
        rst <= 1'b0;
        cyc(2);
        chk_flag("a-to-b full_n", 1'b1, ab_n);
        chk_flag("b-to-a full_n", 1'b1, ba_n);
        chk_flag("high warning", 1'b1, high_n);
        reg_op(1'b0, REG_OFFSETS, 32'h0008_0008);
        reg_op(1'b0, 4'hC, 32'h0000_0000);
        for (int i = 0; i < 50 && space !== 1'b1; i++) cyc(1);
        chk_flag("write space", 1'b1, space);
        reg_op(1'b1, REG_OFFSETS, 32'h0400_0008);
        reg_op(1'b0, REG_OFFSETS, 32'h0400_0008);
        a_op(1'b1, 1'b1, 36'h1_2345_6789);
        a_op(1'b1, 1'b1, 36'hA_BCDE_F012);
        view <= 1'b1;
        cyc(6);
        chk_flag("a-to-b full_n", 1'b0, ab_n);
        chk_word("a-to-b mail", 36'h1_2345_6789, o_b_bus);
        b_op(2'h2);
        cyc(6);
        chk_flag("a-to-b full_n", 1'b1, ab_n);
        chk_word("a-to-b kept", 36'h1_2345_6789, o_b_bus);
        view <= 1'b0;
        b_data <= 36'h5_5AA5_33CC;
        b_op(2'h3);
        cyc(6);
        chk_flag("b-to-a full_n", 1'b0, ba_n);
        chk_word("b-to-a mail", 36'h5_5AA5_33CC, o_a_bus);
        a_op(1'b0, 1'b1, '0);
        cyc(6);
        chk_flag("b-to-a full_n", 1'b1, ba_n);
        fifo_write(5);
        for (int i = 0; i < 50 && ready !== 1'b1; i++) cyc(1);
        chk_flag("output ready", 1'b1, ready);
        mode <= 1'b1;
        cyc(4);
        fifo_read();
        fifo_read();
        cyc(4);
        expq.push_back(words[0]);
        ridx = 0;
        restart <= 1'b1;
        cyc(1);
        restart <= 1'b0;
        cyc(5);
        chk_flag("ready after restart", 1'b1, ready);
        mode <= 1'b0;
        repeat (4) fifo_read();
        b_op(2'h1);
        ridx++;
        cyc(8);
        chk_flag("empty again", 1'b0, ready);
        fifo_write(1024);
        cyc(8);
        chk_flag("high warning", 1'b1, high_n);
        fifo_write(1);
        cyc(8);
        chk_flag("high warning", 1'b0, high_n);
        reg_op(1'b0, REG_FILL, 32'd1024);
        fifo_read();
        for (int i = 0; i < 12 && high_n !== 1'b1; i++) cyc(1);
        chk_flag("high warning rise", 1'b1, high_n);
        // second reset with the serial offset-load strap set
        rst <= 1'b1;
        ser_en <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        cyc(4);
        chk_flag("space during load", 1'b0, space);
        a_op(1'b1, 1'b0, 36'h0_0000_0001);
        for (int i = SER_BITS - 1; i >= 0; i--) begin
            ser_d  <= ser_word[i];
            ser_sh <= 1'b1;
            cyc(1);
            ser_sh <= 1'b0;
            cyc(1);
        end
        ser_en <= 1'b0;
        for (int i = 0; i < 50 && space !== 1'b1; i++) cyc(1);
        chk_flag("space after load", 1'b1, space);
        chk_flag("write during load", 1'b0, ready);
        reg_op(1'b0, REG_OFFSETS, 32'h0009_0005);
        summarize();
    end
endmodule
